// *** shared/ucpc_pkg.sv ***
// Constants and carrier types for one serial channel with host pins.
// Assumes a single 100 MHz reference clock for all users.
`default_nettype none
package ucpc_pkg;
  localparam int CLK_HZ = 100_000_000;
  localparam int BAUD_HZ = 115_200;
  localparam int BIT_CYCLES = CLK_HZ / BAUD_HZ;
  localparam int CHAR_BITS = 10;
  localparam int TIMEOUT_CHARS = 4;
  localparam int TIMEOUT_CYCLES = TIMEOUT_CHARS * CHAR_BITS * BIT_CYCLES;
  localparam int FIFO_DEPTH = 8;
  localparam logic [2:0] REG_DATA = 3'h0;
  localparam logic [2:0] REG_IER = 3'h1;
  localparam logic [2:0] REG_EFR = 3'h2;
  localparam logic [2:0] REG_TRIG = 3'h3;
  localparam logic [2:0] REG_MCR = 3'h4;
  localparam logic [2:0] REG_LSR = 3'h5;
  localparam logic [2:0] REG_MSR = 3'h6;
  localparam logic [2:0] REG_SCR = 3'h7;
  localparam int MCR_DTR = 0;
  localparam int MCR_RTS = 1;
  localparam int MCR_IRQ_EN = 3;
  localparam int MCR_LOOP = 4;
  localparam int EFR_AUTO_RTS = 6;
  localparam int EFR_AUTO_CTS = 7;
  localparam int LSR_RX_AVAIL = 0;
  localparam int LSR_RX_ERR = 3;
  localparam int LSR_TX_SPACE = 5;
  localparam int LSR_TX_IDLE = 6;
  localparam logic [7:0] IER_RST = 8'h00;
  localparam logic [7:0] EFR_RST = 8'h00;
  localparam logic [7:0] MCR_RST = 8'h00;
  localparam logic [7:0] TRIG_RST = 8'h41;
  localparam logic [3:0] MODEM_IDLE = 4'hF;

  typedef struct packed {
    logic dcd_n;
    logic ri_n;
    logic dsr_n;
    logic cts_n;
  } ucpc_modem_type;

  typedef struct packed {
    logic       err;
    logic [7:0] data;
  } ucpc_rx_word_type;

  typedef enum logic [1:0] {
    TX_IDLE,
    TX_START,
    TX_DATA,
    TX_STOP
  } ucpc_tx_state_type;

  typedef enum logic [1:0] {
    RX_IDLE,
    RX_START,
    RX_DATA,
    RX_STOP
  } ucpc_rx_state_type;
endpackage
`default_nettype wire

// *** design/ucpc_channel.sv ***
// One serial channel: host strobe bus, modem pins, FIFOs and DMA flags.
// Assumes all inputs synchronous to ref_clk_i; a second channel is a
// second instance sharing only the data bus wiring and the clock.
`timescale 1ns/1ps
`default_nettype none

module ucpc_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
) (
  input  wire logic                         ref_clk_i,
  input  wire logic                         sys_rst_i,
  input  wire logic                         in_valid_i,
  output logic                              in_ready_o,
  input  wire logic [WIDTH-1:0]             in_data_i,
  output logic                              out_valid_o,
  input  wire logic                         out_ready_i,
  output logic [WIDTH-1:0]                  out_data_o,
  output logic [$clog2(DEPTH+1)-1:0]        count_o
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wp;
    logic [AW-1:0]               rp;
    logic [CW-1:0]               cnt;
  } ucpc_fifo_state_type;

  ucpc_fifo_state_type state_reg;
  ucpc_fifo_state_type state_next;
  logic                push;
  logic                pop;

  assign in_ready_o = state_reg.cnt != CW'(DEPTH);
  assign out_valid_o = state_reg.cnt != '0;
  assign out_data_o = state_reg.mem[state_reg.rp];
  assign count_o = state_reg.cnt;
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;

  always_comb begin
    state_next = state_reg;
    if (push) begin
      state_next.mem[state_reg.wp] = in_data_i;
      state_next.wp = (state_reg.wp == AW'(DEPTH - 1)) ? '0 : state_reg.wp + 1'b1;
    end
    if (pop) begin
      state_next.rp = (state_reg.rp == AW'(DEPTH - 1)) ? '0 : state_reg.rp + 1'b1;
    end
    case ({push, pop})
      2'b10: state_next.cnt = state_reg.cnt + 1'b1;
      2'b01: state_next.cnt = state_reg.cnt - 1'b1;
      default: state_next.cnt = state_reg.cnt;
    endcase
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end
endmodule

module ucpc_channel
  import ucpc_pkg::*;
#(
  parameter int BIT_LEN = BIT_CYCLES,
  parameter int TIMEOUT_LEN = TIMEOUT_CYCLES,
  parameter int DEPTH = FIFO_DEPTH
) (
  input  wire logic           ref_clk_i,
  input  wire logic           sys_rst_i,
  input  wire logic           channel_select_n_i,
  input  wire logic [2:0]     register_select_i,
  input  wire logic           host_read_strobe_n_i,
  input  wire logic           host_write_strobe_n_i,
  input  wire logic [7:0]     host_data_bus_i,
  output logic [7:0]          host_data_bus_o,
  output logic                host_data_bus_oe_n_o,
  input  wire logic           serial_in_i,
  output logic                serial_out_o,
  input  wire ucpc_modem_type modem_i,
  output logic                terminal_ready_out_n_o,
  output logic                request_to_send_n_o,
  output logic                channel_irq_out_o,
  output logic                channel_irq_out_oe_n_o,
  output logic                user_output_n_o,
  output logic                rx_dma_request_n_o,
  output logic                tx_dma_request_n_o
);
  localparam int BW = $clog2(BIT_LEN + 1);
  localparam int OW = $clog2(TIMEOUT_LEN + 1);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [BW-1:0] BIT_LAST = BW'(BIT_LEN - 1);
  localparam logic [BW-1:0] BIT_HALF = BW'(BIT_LEN / 2 - 1);
  localparam logic [OW-1:0] TOUT_LAST = OW'(TIMEOUT_LEN);

  typedef struct packed {
    logic              rd_q;
    logic              wr_q;
    logic              wr_cs_q;
    logic [2:0]        wr_addr_q;
    logic [7:0]        wr_data_q;
    logic [7:0]        dout;
    logic              drive;
    logic [7:0]        interrupt_enable_reg;
    logic [7:0]        enhanced_feature_reg;
    logic [7:0]        trig;
    logic [7:0]        modem_control_reg;
    logic [7:0]        scr;
    logic [3:0]        modem_q;
    logic [3:0]        delta;
    logic              rx_err;
    logic              rts_hold;
    logic              rts_n;
    logic              irq;
    logic              rx_rdy_n;
    logic              tx_rdy_n;
    ucpc_tx_state_type tstate;
    logic [BW-1:0]     tcnt;
    logic [2:0]        tbit;
    logic [7:0]        tsh;
    logic              txd;
    ucpc_rx_state_type rstate;
    logic [BW-1:0]     rcnt;
    logic [2:0]        rbit;
    logic [7:0]        rsh;
    logic [OW-1:0]     tout;
  } ucpc_chan_state_type;

  ucpc_chan_state_type state_reg;
  ucpc_chan_state_type state_next;
  ucpc_chan_state_type s;
  logic                rd_edge;
  logic                wr_edge;
  logic                tx_push;
  logic                tx_ready;
  logic                tx_valid;
  logic                tx_pop;
  logic [7:0]          tx_data;
  logic [CW-1:0]       tx_cnt;
  logic                rx_push;
  logic                rx_ready;
  logic                rx_valid;
  logic                rx_pop;
  ucpc_rx_word_type    rx_word;
  ucpc_rx_word_type    rx_head;
  logic [CW-1:0]       rx_cnt;
  logic                rxd;
  logic                ttick;
  logic                rtick;
  logic                tmo;
  logic [3:0]          chg;
  logic [7:0]          lsr;

  assign s = state_reg;

  ucpc_fifo #(
    .WIDTH (8),
    .DEPTH (DEPTH)
  ) u_tx_fifo (
    .ref_clk_i   (ref_clk_i),
    .sys_rst_i   (sys_rst_i),
    .in_valid_i  (tx_push),
    .in_ready_o  (tx_ready),
    .in_data_i   (s.wr_data_q),
    .out_valid_o (tx_valid),
    .out_ready_i (tx_pop),
    .out_data_o  (tx_data),
    .count_o     (tx_cnt)
  );

  ucpc_fifo #(
    .WIDTH (9),
    .DEPTH (DEPTH)
  ) u_rx_fifo (
    .ref_clk_i   (ref_clk_i),
    .sys_rst_i   (sys_rst_i),
    .in_valid_i  (rx_push),
    .in_ready_o  (rx_ready),
    .in_data_i   (rx_word),
    .out_valid_o (rx_valid),
    .out_ready_i (rx_pop),
    .out_data_o  (rx_head),
    .count_o     (rx_cnt)
  );

  always_comb begin
    state_next = s;
    rd_edge = s.rd_q & ~host_read_strobe_n_i & ~channel_select_n_i;
    wr_edge = ~s.wr_q & host_write_strobe_n_i & s.wr_cs_q;
    tx_push = wr_edge & (s.wr_addr_q == REG_DATA);
    rx_pop = rd_edge & (register_select_i == REG_DATA);
    rxd = s.modem_control_reg[MCR_LOOP] ? s.txd : serial_in_i;
    ttick = s.tcnt == BIT_LAST;
    rtick = (s.rstate == RX_START) ? (s.rcnt == BIT_HALF) : (s.rcnt == BIT_LAST);
    tmo = s.tout == TOUT_LAST;
    tx_pop = 1'b0;
    rx_push = 1'b0;
    rx_word = '{err: ~rxd, data: s.rsh};
    lsr = '0;
    lsr[LSR_RX_AVAIL] = rx_valid;
    lsr[LSR_RX_ERR] = s.rx_err;
    lsr[LSR_TX_SPACE] = tx_ready;
    lsr[LSR_TX_IDLE] = ~tx_valid & (s.tstate == TX_IDLE);
    state_next.rd_q = host_read_strobe_n_i;
    state_next.wr_q = host_write_strobe_n_i;
    state_next.wr_cs_q = ~channel_select_n_i;
    state_next.wr_addr_q = register_select_i;
    state_next.wr_data_q = host_data_bus_i;
    if (rd_edge) begin
      state_next.drive = 1'b1;
      case (register_select_i)
        REG_DATA: state_next.dout = rx_valid ? rx_head.data : 8'h00;
        REG_IER: state_next.dout = s.interrupt_enable_reg;
        REG_EFR: state_next.dout = s.enhanced_feature_reg;
        REG_TRIG: state_next.dout = s.trig;
        REG_MCR: state_next.dout = s.modem_control_reg;
        REG_LSR: state_next.dout = lsr;
        REG_MSR: state_next.dout = {~s.modem_q, s.delta};
        default: state_next.dout = s.scr;
      endcase
      if (register_select_i == REG_LSR) begin
        state_next.rx_err = 1'b0;
      end
      if (register_select_i == REG_MSR) begin
        state_next.delta = 4'h0;
      end
    end else if (host_read_strobe_n_i | channel_select_n_i) begin
      state_next.drive = 1'b0;
    end
    if (wr_edge) begin
      case (s.wr_addr_q)
        REG_IER: state_next.interrupt_enable_reg = s.wr_data_q;
        REG_EFR: state_next.enhanced_feature_reg = s.wr_data_q;
        REG_TRIG: state_next.trig = s.wr_data_q;
        REG_MCR: state_next.modem_control_reg = s.wr_data_q;
        REG_SCR: state_next.scr = s.wr_data_q;
        default: state_next.scr = s.scr;
      endcase
    end
    state_next.modem_q = modem_i;
    chg = s.modem_q ^ modem_i;
    chg[2] = ~s.modem_q[2] & modem_i.ri_n;
    // Auto clear to send owns the transmitter, so its edges stay quiet
    chg[0] = chg[0] & ~s.enhanced_feature_reg[EFR_AUTO_CTS];
    state_next.delta = state_next.delta | {chg[3], chg[2], chg[1], chg[0]};
    // Transmitter
    state_next.tcnt = (s.tstate == TX_IDLE || ttick) ? '0 : s.tcnt + 1'b1;
    case (s.tstate)
      TX_IDLE: begin
        if (tx_valid & (~s.enhanced_feature_reg[EFR_AUTO_CTS] | ~modem_i.cts_n)) begin
          tx_pop = 1'b1;
          state_next.tsh = tx_data;
          state_next.txd = 1'b0;
          state_next.tstate = TX_START;
        end
      end
      TX_START: begin
        if (ttick) begin
          state_next.txd = s.tsh[0];
          state_next.tbit = 3'h0;
          state_next.tstate = TX_DATA;
        end
      end
      TX_DATA: begin
        if (ttick) begin
          state_next.tsh = {1'b0, s.tsh[7:1]};
          state_next.tbit = s.tbit + 1'b1;
          state_next.txd = s.tsh[1];
          if (s.tbit == 3'h7) begin
            state_next.txd = 1'b1;
            state_next.tstate = TX_STOP;
          end
        end
      end
      TX_STOP: begin
        if (ttick) begin
          state_next.tstate = TX_IDLE;
        end
      end
      default: state_next.tstate = TX_IDLE;
    endcase
    // Receiver, sampled at mid bit
    state_next.rcnt = (s.rstate == RX_IDLE || rtick) ? '0 : s.rcnt + 1'b1;
    case (s.rstate)
      RX_IDLE: begin
        if (!rxd) begin
          state_next.rstate = RX_START;
        end
      end
      RX_START: begin
        if (rtick) begin
          state_next.rbit = 3'h0;
          state_next.rstate = rxd ? RX_IDLE : RX_DATA;
        end
      end
      RX_DATA: begin
        if (rtick) begin
          // First bit lands in bit zero
          state_next.rsh = {rxd, s.rsh[7:1]};
          state_next.rbit = s.rbit + 1'b1;
          if (s.rbit == 3'h7) begin
            state_next.rstate = RX_STOP;
          end
        end
      end
      RX_STOP: begin
        if (rtick) begin
          rx_push = 1'b1;
          state_next.rstate = RX_IDLE;
        end
      end
      default: state_next.rstate = RX_IDLE;
    endcase
    // Framing or overrun error; the set wins over a status read
    if (rx_push & (~rxd | ~rx_ready)) begin
      state_next.rx_err = 1'b1;
    end
    // Character timeout while data waits unread
    if (!rx_valid || rx_push || rx_pop) begin
      state_next.tout = '0;
    end else if (!tmo) begin
      state_next.tout = s.tout + 1'b1;
    end
    if (!rx_valid || s.rx_err) begin
      state_next.rx_rdy_n = 1'b1;
    end else if (8'(rx_cnt) >= {4'h0, s.trig[3:0]} || tmo) begin
      state_next.rx_rdy_n = 1'b0;
    end
    if (!tx_ready) begin
      state_next.tx_rdy_n = 1'b1;
    end else if (8'(DEPTH) - 8'(tx_cnt) >= {4'h0, s.trig[7:4]}) begin
      state_next.tx_rdy_n = 1'b0;
    end
    if (!rx_valid) begin
      state_next.rts_hold = 1'b0;
    end else if (8'(rx_cnt) >= {4'h0, s.trig[3:0]}) begin
      state_next.rts_hold = 1'b1;
    end
    state_next.rts_n = ~s.modem_control_reg[MCR_RTS] | (s.enhanced_feature_reg[EFR_AUTO_RTS] & s.rts_hold);
    state_next.irq = |({|s.delta, s.rx_err, tx_ready, rx_valid} & s.interrupt_enable_reg[3:0]);
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_reg <= '0;
      state_reg.rd_q <= 1'b1;
      state_reg.wr_q <= 1'b1;
      state_reg.interrupt_enable_reg <= IER_RST;
      state_reg.enhanced_feature_reg <= EFR_RST;
      state_reg.trig <= TRIG_RST;
      state_reg.modem_control_reg <= MCR_RST;
      state_reg.modem_q <= MODEM_IDLE;
      state_reg.rts_n <= 1'b1;
      state_reg.rx_rdy_n <= 1'b1;
      state_reg.tx_rdy_n <= 1'b1;
      state_reg.txd <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  assign host_data_bus_o = s.dout;
  assign host_data_bus_oe_n_o = ~s.drive;
  assign serial_out_o = s.modem_control_reg[MCR_LOOP] | s.txd;
  assign terminal_ready_out_n_o = ~s.modem_control_reg[MCR_DTR];
  assign request_to_send_n_o = s.rts_n;
  assign channel_irq_out_o = s.irq & s.modem_control_reg[MCR_IRQ_EN];
  assign channel_irq_out_oe_n_o = ~s.modem_control_reg[MCR_IRQ_EN];
  assign user_output_n_o = ~s.modem_control_reg[MCR_IRQ_EN];
  assign rx_dma_request_n_o = s.rx_rdy_n;
  assign tx_dma_request_n_o = s.tx_rdy_n;
endmodule

`default_nettype wire

// *** sim/ucpc_channel_chk.sv ***
// Port-level properties of one serial channel with host strobe pins.
// Assumes a bind into ucpc_channel; sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module ucpc_channel_chk
  import ucpc_pkg::*;
#(
  parameter int BIT_LEN = BIT_CYCLES
) (
  input wire logic       ref_clk_i,
  input wire logic       sys_rst_i,
  input wire logic       channel_select_n_i,
  input wire logic [2:0] register_select_i,
  input wire logic       host_read_strobe_n_i,
  input wire logic       host_write_strobe_n_i,
  input wire logic [7:0] host_data_bus_i,
  input wire logic       host_data_bus_oe_n_o,
  input wire logic       serial_out_o,
  input wire logic       terminal_ready_out_n_o,
  input wire logic       user_output_n_o,
  input wire logic       channel_irq_out_o,
  input wire logic       channel_irq_out_oe_n_o,
  input wire logic       tx_dma_request_n_o
);
  logic       wr_prev_reg;
  logic       cs_prev_reg;
  logic [7:0] low_cnt_reg;
  logic       wr_det;
  // Counts the low run so bit cells can be checked without long repetitions
  assign wr_det = host_write_strobe_n_i & ~wr_prev_reg & ~cs_prev_reg;
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wr_prev_reg <= 1'h1;
      cs_prev_reg <= 1'h1;
      low_cnt_reg <= 8'h00;
    end else begin
      wr_prev_reg <= host_write_strobe_n_i;
      cs_prev_reg <= channel_select_n_i;
      low_cnt_reg <= serial_out_o ? 8'h00 : low_cnt_reg + 8'h01;
    end
  end
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (sys_rst_i);
  a_reset_state:
    assert property ($fell(sys_rst_i) |-> terminal_ready_out_n_o && user_output_n_o
      && channel_irq_out_oe_n_o && !channel_irq_out_o && host_data_bus_oe_n_o
      && serial_out_o && tx_dma_request_n_o) else $error("reset state wrong");
  a_txdma_init:
    assert property ($fell(sys_rst_i) |=> !tx_dma_request_n_o)
      else $error("tx request not low with empty buffer");
  a_dtr_write:
    assert property ($rose(host_write_strobe_n_i) && !$past(channel_select_n_i)
      && $past(register_select_i) == REG_MCR
      |=> terminal_ready_out_n_o == !$past(host_data_bus_i[0], 2))
      else $error("terminal ready does not follow write");
  a_op_write:
    assert property ($rose(host_write_strobe_n_i) && !$past(channel_select_n_i)
      && $past(register_select_i) == REG_MCR
      |=> user_output_n_o == !$past(host_data_bus_i[3], 2))
      else $error("user output does not follow write");
  a_dtr_hold:
    assert property ($changed(terminal_ready_out_n_o) |-> $past(wr_det))
      else $error("terminal ready moved without a write");
  a_op_pair:
    assert property (user_output_n_o == channel_irq_out_oe_n_o)
      else $error("user output and interrupt enable disagree");
  a_irq_gated:
    assert property (channel_irq_out_oe_n_o |-> !channel_irq_out_o)
      else $error("interrupt active while pin floats");
  a_read_drive:
    assert property ($fell(host_read_strobe_n_i) && !channel_select_n_i
      |=> !host_data_bus_oe_n_o) else $error("read not driven");
  a_read_release:
    assert property (host_read_strobe_n_i && $past(host_read_strobe_n_i)
      |-> host_data_bus_oe_n_o) else $error("bus held after read");
  a_bit_timing:
    assert property ($rose(serial_out_o) |-> low_cnt_reg != 8'h00
      && low_cnt_reg % BIT_LEN == 0) else $error("bit cell length wrong");
  c_irq: cover property ($rose(channel_irq_out_o));
  c_frame: cover property ($fell(serial_out_o));
  c_write: cover property (wr_det);
endmodule
bind ucpc_channel ucpc_channel_chk #(.BIT_LEN(BIT_LEN)) chk_u (
  .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
  .channel_select_n_i(channel_select_n_i), .register_select_i(register_select_i),
  .host_read_strobe_n_i(host_read_strobe_n_i),
  .host_write_strobe_n_i(host_write_strobe_n_i), .host_data_bus_i(host_data_bus_i),
  .host_data_bus_oe_n_o(host_data_bus_oe_n_o), .serial_out_o(serial_out_o),
  .terminal_ready_out_n_o(terminal_ready_out_n_o), .user_output_n_o(user_output_n_o),
  .channel_irq_out_o(channel_irq_out_o), .channel_irq_out_oe_n_o(channel_irq_out_oe_n_o),
  .tx_dma_request_n_o(tx_dma_request_n_o));
`default_nettype wire

// *** sim/ucpc_peer.sv ***
// Serial peer on the far side of the channel: sends and collects 8N1 bytes.
// Assumes the bench clock and the same bit length as the design.
`timescale 1ns/1ps
`default_nettype none
module ucpc_peer #(
  parameter int BIT_LEN = 8
) (
  input  wire logic ref_clk_i,
  input  wire logic line_i,
  output logic      line_o
);
  logic [7:0] got[$];
  initial line_o = 1'h1;
  task automatic send(input logic [7:0] b, input int gap);
    logic [9:0] f;
    f = {1'h1, b, 1'h0};
    repeat (gap) @(posedge ref_clk_i);
    // Keeps the start bit off the sampling edge, like every later bit
    #1;
    for (int i = 0; i < 10; i++) begin
      line_o = f[i];
      repeat (BIT_LEN) @(posedge ref_clk_i);
      #1;
    end
  endtask
  // Samples mid-cell; a glitch shorter than half a bit still starts a frame
  initial begin
    logic [7:0] b;
    forever begin
      @(negedge line_i);
      repeat (BIT_LEN / 2) @(posedge ref_clk_i);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT_LEN) @(posedge ref_clk_i);
        b[i] = line_i;
      end
      repeat (BIT_LEN) @(posedge ref_clk_i);
      got.push_back(b);
    end
  end
endmodule
`default_nettype wire

// *** sim/ucpc_channel_tb.sv ***
// Self-checking bench for one serial channel with host strobe pins.
// Assumes the serial peer model and a shortened bit length.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin mismatches++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end
module ucpc_channel_tb
  import ucpc_pkg::*;
;
  localparam int BL = 8;
  logic           ref_clk_i;
  logic           sys_rst_i;
  logic           cs_n;
  logic [2:0]     sel;
  logic           rd_n;
  logic           wr_n;
  logic [7:0]     din;
  logic [7:0]     dout;
  logic           oe_n;
  logic           s_in;
  logic           s_out;
  ucpc_modem_type modem;
  logic           dtr_n, rts_n, irq, irq_oe_n, op_n, rxd_n, txd_n;
  logic [7:0]     txq[$];
  int             mismatches = 0;
  int             n_checks = 0;
  int unsigned    seed = 35;
  initial begin
    ref_clk_i = 1'h0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  ucpc_channel #(.BIT_LEN(BL), .TIMEOUT_LEN(200), .DEPTH(8)) dut_u (
    .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .channel_select_n_i(cs_n),
    .register_select_i(sel), .host_read_strobe_n_i(rd_n), .host_write_strobe_n_i(wr_n),
    .host_data_bus_i(din), .host_data_bus_o(dout), .host_data_bus_oe_n_o(oe_n),
    .serial_in_i(s_in), .serial_out_o(s_out), .modem_i(modem),
    .terminal_ready_out_n_o(dtr_n), .request_to_send_n_o(rts_n),
    .channel_irq_out_o(irq), .channel_irq_out_oe_n_o(irq_oe_n), .user_output_n_o(op_n),
    .rx_dma_request_n_o(rxd_n), .tx_dma_request_n_o(txd_n));
  ucpc_peer #(.BIT_LEN(BL)) peer_u (.ref_clk_i(ref_clk_i), .line_i(s_out), .line_o(s_in));
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask
  task automatic bus(input logic w, input logic [2:0] a, input logic [7:0] d,
                     input logic c, output logic [7:0] q);
    cs_n = c;
    sel = a;
    din = d;
    if (w) wr_n = 1'h0;
    else rd_n = 1'h0;
    cyc(2);
    q = dout;
    wr_n = 1'h1;
    rd_n = 1'h1;
    cyc(2);
    cs_n = 1'h1;
    cyc(1);
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'h1, a, d, 1'h0, q);
  endtask
  task automatic rdc(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e);
    logic [7:0] q;
    bus(1'h0, a, 8'h00, 1'h0, q);
    `CHK(q & m, e)
  endtask
  task automatic chk_tx(input int n);
    int k;
    logic [7:0] g;
    logic [7:0] e;
    k = 0;
    while (peer_u.got.size() < n && k < 2000) begin
      cyc(1);
      k++;
    end
    if (peer_u.got.size() < n) mismatches++;
    for (int i = 0; i < n; i++) begin
      g = peer_u.got.pop_front();
      e = txq.pop_front();
      `CHK(g, e)
    end
  endtask
  task automatic end_sim();
    $display("checks=%0d mismatches=%0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    cyc(20000);
    mismatches++;
    end_sim();
  end
  initial begin
    logic [7:0] r;
    logic [7:0] q;
    sys_rst_i = 1'h1;
    cs_n = 1'h1;
    sel = 3'h0;
    rd_n = 1'h1;
    wr_n = 1'h1;
    din = 8'h00;
    modem = MODEM_IDLE;
    cyc(10);
    sys_rst_i = 1'h0;
    cyc(2);
    `CHK({dtr_n, rts_n, op_n, irq_oe_n, irq, rxd_n, txd_n, s_out, oe_n}, 9'h1EB);
    rdc(REG_TRIG, 8'hFF, TRIG_RST);
    rdc(REG_MCR, 8'hFF, MCR_RST);
    rdc(REG_IER, 8'hFF, IER_RST);
    rdc(REG_EFR, 8'hFF, EFR_RST);
    for (int i = 0; i < 8; i++) begin
      wr(REG_MCR, {4'h0, i[2], 1'h0, i[1], i[0]});
      cyc(2);
      `CHK({dtr_n, rts_n, op_n, irq_oe_n, irq}, {~i[0], ~i[1], ~i[2], ~i[2], 1'h0});
    end
    wr(REG_MSR, 8'hFF);
    rdc(REG_MSR, 8'hF0, 8'h00);
    r = rnd();
    wr(REG_SCR, r);
    bus(1'h1, REG_SCR, ~r, 1'h1, q);
    rdc(REG_SCR, 8'hFF, r);
    wr(REG_MCR, 8'h08);
    wr(REG_IER, 8'h02);
    cyc(2);
    `CHK(irq, 1'h1);
    wr(REG_IER, 8'h00);
    cyc(2);
    `CHK(irq, 1'h0);
    for (int i = 0; i < 3; i++) begin
      r = rnd();
      txq.push_back(r);
      wr(REG_DATA, r);
    end
    chk_tx(3);
    // Auto clear-to-send stalls the transmitter so the buffer fills
    wr(REG_EFR, 8'h80);
    modem.cts_n = 1'h1;
    for (int i = 0; i < 9; i++) begin
      r = rnd();
      if (i < 8) txq.push_back(r);
      wr(REG_DATA, r);
    end
    cyc(2);
    `CHK({txd_n, s_out}, 2'h3);
    rdc(REG_LSR, 8'h20, 8'h00);
    modem.cts_n = 1'h0;
    // Status shows the pin one cycle late
    cyc(2);
    rdc(REG_MSR, 8'h10, 8'h10);
    chk_tx(8);
    cyc(2 * BL);
    `CHK(txd_n, 1'h0);
    rdc(REG_LSR, 8'h40, 8'h40);
    wr(REG_EFR, 8'h40);
    wr(REG_MCR, 8'h0A);
    wr(REG_IER, 8'h01);
    cyc(2);
    `CHK(rts_n, 1'h0);
    r = rnd();
    peer_u.send(r, 3);
    cyc(BL);
    `CHK({rts_n, rxd_n, irq}, 3'h5);
    rdc(REG_LSR, 8'h01, 8'h01);
    rdc(REG_DATA, 8'hFF, r);
    cyc(2);
    `CHK({rts_n, rxd_n, irq}, 3'h2);
    // Trigger of two leaves a lone byte for the timeout to report
    wr(REG_TRIG, 8'h42);
    r = rnd();
    peer_u.send(r, 3);
    cyc(BL);
    `CHK({rts_n, rxd_n}, 2'h1);
    cyc(220);
    `CHK(rxd_n, 1'h0);
    rdc(REG_DATA, 8'hFF, r);
    bus(1'h0, REG_MSR, 8'h00, 1'h0, q);
    wr(REG_IER, 8'h08);
    modem.ri_n = 1'h0;
    cyc(3);
    `CHK(irq, 1'h0);
    rdc(REG_MSR, 8'h40, 8'h40);
    modem.ri_n = 1'h1;
    cyc(3);
    `CHK(irq, 1'h1);
    bus(1'h0, REG_MSR, 8'h00, 1'h0, q);
    cyc(2);
    `CHK(irq, 1'h0);
    // Peer drives the opposite byte to prove the pin is ignored
    wr(REG_MCR, 8'h10);
    r = rnd();
    fork
      peer_u.send(~r, 0);
      wr(REG_DATA, r);
    join
    cyc(12 * BL);
    `CHK({s_out, peer_u.got.size() == 0}, 2'h3);
    rdc(REG_DATA, 8'hFF, r);
    cyc(5);
    end_sim();
  end
endmodule
`default_nettype wire
